// file: design/sfr_core.sv
// sample fifo, event flags and register map of the pulse sensor
// Overview of operation
// - supply rising above lockout sets the supply-up flag
// - four event sources have mask bits; supply-up always drives the interrupt
// - brownout resets state, leaving every maskable source disabled
// - masked source still sets its status bit but keeps interrupt high
// - 4-bit write position names next slot, advances per stored sample
// - host write to write position accepted only when mode nonzero
// - full fifo drops new samples, lost count increments, saturating at fifteen
// - lost count clears whenever the read position advances
// - host may write read position to re-fetch samples
// - circular buffer of sixteen four-byte entries, ir then red
// - data port reads keep the register address, returning next fifo byte
// - other registers advance the address after each burst byte
// - address does not wrap after the top register; later bytes meaningless
// - read position advances only after all four sample bytes read
// - results stored left-justified, msb at bit fifteen
// - samples stored in pulse-only mode read zero in third and fourth bytes
// - pointers survive mode changes, cleared by lockout, srst or a host write of zero
// - interrupt low while enabled flag set; status or data read clears
// - almost-full raised when write equals read minus one in active modes
module sfr_core import sfr_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             irq_n,
    input  wire logic        supply_ok,
    input  wire logic [2:0]  op_mode,
    input  wire logic        smp_valid,
    input  wire logic [15:0] smp_ir,
    input  wire logic [15:0] smp_red,
    input  wire logic [1:0]  smp_res,
    input  wire logic        temp_done
);

    typedef struct packed {
        logic       sup_m, sup_s, sup_d;
        logic [3:0] mask;
        logic [3:0] wr_pos;
        logic [3:0] rd_pos;
        logic [3:0] lost;
        logic       full;
        logic [1:0] byte_idx;
        logic [7:0] reg_ptr;
        logic       ptr_top;
        logic [3:0] flags;
        logic       pwr;
        logic       irq_n;
    } sfr_core_s;

    localparam sfr_core_s SFR_CORE_RST = '{
        mask: SFR_MASK_RST, wr_pos: SFR_PTR_RST, rd_pos: SFR_PTR_RST,
        lost: SFR_LOST_RST, irq_n: 1'b1, default: '0};

    sfr_core_s   q, n;
    sfr_ev_s     ev;
    // one word per sample, so a push can never be seen half written
    logic [31:0] fifo_mem [SFR_DEPTH];
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic [7:0]  rd_byte;
    logic        active_mode;
    logic        push_ok;
    logic [3:0]  push_addr;

    sfr_i2c_target u_i2c (
        .mclk    (mclk),
        .srst    (srst),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .rd_byte (rd_byte),
        .sda_o   (sda_o),
        .sda_oe  (sda_oe),
        .ev      (ev)
    );

    // shift a right-justified result so its msb lands at bit 15
    function automatic logic [15:0] left_just(input logic [15:0] raw, input logic [1:0] res);
        case (res)
            2'h0:    left_just = {raw[12:0], 3'h0};
            2'h1:    left_just = {raw[13:0], 2'h0};
            2'h2:    left_just = {raw[14:0], 1'h0};
            default: left_just = raw;
        endcase
    endfunction

    assign active_mode = (op_mode == SFR_MODE_HR) || (op_mode == SFR_MODE_OXI);

    // whole sample in one word; red forced to zero in pulse-only mode
    assign wr_word = {left_just(smp_ir, smp_res),
                      (op_mode == SFR_MODE_HR) ? 16'h0000 : left_just(smp_red, smp_res)};

    // whole sample word under the read position; the mux below picks the byte
    assign rd_word = fifo_mem[q.rd_pos];

    // read mux; the engine latches this on its own edge
    always_comb begin
        rd_byte = SFR_RDATA_RST;
        if (q.ptr_top) begin
            rd_byte = SFR_RDATA_RST;
        end else if (q.reg_ptr == SFR_REG_STATUS) begin
            rd_byte = {q.flags, 3'h0, q.pwr};
        end else if (q.reg_ptr == SFR_REG_MASK) begin
            rd_byte = {q.mask, 4'h0};
        end else if (q.reg_ptr == SFR_REG_WRPOS) begin
            rd_byte = {4'h0, q.wr_pos};
        end else if (q.reg_ptr == SFR_REG_LOST) begin
            rd_byte = {4'h0, q.lost};
        end else if (q.reg_ptr == SFR_REG_RDPOS) begin
            rd_byte = {4'h0, q.rd_pos};
        end else if (q.reg_ptr == SFR_REG_DATA) begin
            case (q.byte_idx)
                2'h0:    rd_byte = rd_word[31:24];
                2'h1:    rd_byte = rd_word[23:16];
                2'h2:    rd_byte = rd_word[15:8];
                default: rd_byte = rd_word[7:0];
            endcase
        end
    end

    // next state: host ops first, then device events so a set beats a clear
    always_comb begin
        n = q;
        push_ok = 1'b0;
        push_addr = q.wr_pos;
        n.sup_m = supply_ok;
        n.sup_s = q.sup_m;
        n.sup_d = q.sup_s;

        // address register load and register writes
        if (ev.wr && ev.ptr) begin
            n.reg_ptr = ev.data;
            n.ptr_top = 1'b0;
        end else if (ev.wr) begin
            if (q.reg_ptr == SFR_REG_MASK) begin
                n.mask = ev.data[7:4];
            end else if (q.reg_ptr == SFR_REG_WRPOS && op_mode != SFR_MODE_OFF) begin
                n.wr_pos = ev.data[3:0];
                n.full = 1'b0;
            end else if (q.reg_ptr == SFR_REG_LOST) begin
                n.lost = ev.data[3:0];
            end else if (q.reg_ptr == SFR_REG_RDPOS) begin
                n.rd_pos = ev.data[3:0];
                n.byte_idx = 2'h0;
                n.full = 1'b0;
            end
        end

        // reads: clear-on-read and fifo byte stepping
        if (ev.rd) begin
            if (q.reg_ptr == SFR_REG_STATUS || q.reg_ptr == SFR_REG_DATA) begin
                n.flags = 4'h0;
                n.pwr = 1'b0;
            end
            if (q.reg_ptr == SFR_REG_DATA && !q.ptr_top) begin
                n.byte_idx = q.byte_idx + 2'h1;
                if (q.byte_idx == SFR_LAST_BYTE) begin
                    n.rd_pos = q.rd_pos + 4'h1;
                    n.lost = SFR_LOST_RST;
                    n.full = 1'b0;
                end
            end
        end

        // address stepping after each byte, held on the data port and at the top
        if ((ev.rd || (ev.wr && !ev.ptr)) && q.reg_ptr != SFR_REG_DATA) begin
            if (q.reg_ptr == SFR_REG_LAST) begin
                n.ptr_top = 1'b1;
            end else begin
                n.reg_ptr = q.reg_ptr + 8'h01;
            end
        end

        // sample arrival
        if (smp_valid) begin
            if (n.full) begin
                if (n.lost != SFR_LOST_MAX) begin
                    n.lost = n.lost + 4'h1;
                end
            end else begin
                push_ok = 1'b1;
                push_addr = n.wr_pos;
                n.wr_pos = n.wr_pos + 4'h1;
                n.full = (n.wr_pos == n.rd_pos);
                if (active_mode && (n.wr_pos == n.rd_pos - 4'h1)) begin
                    n.flags[SFR_F_AFULL] = 1'b1;
                end
            end
            if (active_mode) begin
                n.flags[SFR_F_PULSE] = 1'b1;
            end
            if (op_mode == SFR_MODE_OXI) begin
                n.flags[SFR_F_OXI] = 1'b1;
            end
        end
        if (temp_done) begin
            n.flags[SFR_F_TEMP] = 1'b1;
        end

        // supply rising through lockout
        if (q.sup_s && !q.sup_d) begin
            n.pwr = 1'b1;
        end

        // below lockout: core register state back to defaults; fifo words and serial engine untouched
        if (!q.sup_s) begin
            n = SFR_CORE_RST;
            n.sup_m = supply_ok;
            n.sup_s = q.sup_m;
            n.sup_d = q.sup_s;
            push_ok = 1'b0;
        end

        // supply-up bypasses the mask, events need their enable
        n.irq_n = ~(n.pwr | (|(n.flags & n.mask)));
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= SFR_CORE_RST;
        end else begin
            q <= n;
        end
    end

    // sample storage; no reset needed, pointers guard the contents
    always_ff @(posedge mclk) begin
        if (push_ok && !srst) begin
            fifo_mem[push_addr] <= wr_word;
        end
    end

    assign irq_n = q.irq_n;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_last_byte_read;
        ev.rd && q.reg_ptr == SFR_REG_DATA && !q.ptr_top && q.byte_idx == SFR_LAST_BYTE;
    endsequence

    sequence s_brownout;
        !q.sup_s ##1 !q.sup_s;
    endsequence

    // a host data byte with no sample competing for the pointers
    sequence s_ptr_write;
        ev.wr && !ev.ptr && q.sup_s && !smp_valid;
    endsequence

    AST_RD_ADVANCE: assert property (
        s_last_byte_read and q.sup_s |=> q.rd_pos == $past(q.rd_pos) + 4'h1 && q.byte_idx == 2'h0)
        else $error("read position did not advance after fourth byte");

    AST_RD_PARTIAL: assert property (
        ev.rd && q.reg_ptr == SFR_REG_DATA && q.byte_idx != SFR_LAST_BYTE && !ev.wr
        |=> q.rd_pos == $past(q.rd_pos))
        else $error("read position moved on a partial sample");

    AST_LOST_CLEAR: assert property (
        s_last_byte_read and (!smp_valid && !ev.wr) |=> q.lost == 4'h0)
        else $error("lost count not cleared on pop");

    AST_LOST_SAT: assert property (
        q.sup_s && q.full && q.lost == 4'hF && smp_valid && !ev.wr && !ev.rd
        |=> q.lost == 4'hF && q.wr_pos == $past(q.wr_pos))
        else $error("lost count left saturation or full fifo stored");

    AST_LOST_INC: assert property (
        q.sup_s && q.full && q.lost < 4'hF && smp_valid && !ev.wr && !ev.rd
        |=> q.lost == $past(q.lost) + 4'h1)
        else $error("lost count missed a dropped sample");

    AST_WR_ADVANCE: assert property (
        q.sup_s && !q.full && smp_valid && !ev.wr |=> q.wr_pos == $past(q.wr_pos) + 4'h1)
        else $error("write position did not advance on store");

    AST_WRPOS_LOCK: assert property (
        ev.wr && !ev.ptr && q.reg_ptr == SFR_REG_WRPOS && op_mode == SFR_MODE_OFF
        && !smp_valid |=> q.wr_pos == $past(q.wr_pos))
        else $error("write position changed while mode is off");

    AST_DATA_ADDR_HOLD: assert property (
        ev.rd && q.reg_ptr == SFR_REG_DATA |=> q.reg_ptr == SFR_REG_DATA)
        else $error("address moved on a data port read");

    AST_ADDR_STEP: assert property (
        q.sup_s && ev.rd && q.reg_ptr != SFR_REG_DATA && q.reg_ptr != SFR_REG_LAST
        |=> q.reg_ptr == $past(q.reg_ptr) + 8'h01)
        else $error("address did not step after a byte");

    AST_ADDR_TOP: assert property (
        q.sup_s && ev.rd && q.reg_ptr == SFR_REG_LAST |=> q.reg_ptr == SFR_REG_LAST && q.ptr_top)
        else $error("address wrapped past the top register");

    AST_BROWNOUT: assert property (
        s_brownout |=> q.mask == 4'h0 && q.wr_pos == 4'h0 && q.rd_pos == 4'h0 && q.irq_n)
        else $error("state survived a lockout");

    AST_SUPPLY_UP: assert property (
        q.sup_s && !q.sup_d |=> q.pwr && !q.irq_n)
        else $error("supply rise did not flag and drive interrupt");

    AST_MASKED_QUIET: assert property (
        q.sup_s && temp_done && !q.mask[SFR_F_TEMP] && !q.pwr && !(|(q.flags & q.mask))
        && !smp_valid && !(q.sup_s && !q.sup_d)
        |=> q.flags[SFR_F_TEMP] && q.irq_n)
        else $error("masked source pulled interrupt or lost its flag");

    AST_IRQ_RELEASE: assert property (
        q.sup_s && ev.rd && q.reg_ptr == SFR_REG_STATUS && !smp_valid && !temp_done
        && !(q.sup_s && !q.sup_d) |=> q.irq_n && q.flags == 4'h0 ##1 q.irq_n)
        else $error("status read did not release interrupt");

    AST_AFULL: assert property (
        q.sup_s && !q.full && smp_valid && active_mode && !ev.wr && !ev.rd
        && q.wr_pos + 4'h2 == q.rd_pos |=> q.flags[SFR_F_AFULL])
        else $error("almost-full not raised with one free slot");

    // host pointer writes, idle pointers across mode changes, stored layout
    // note: pointers may only move on a sample, a host byte or a lockout, never on a mode change
    AST_WRPOS_TAKE: assert property (
        s_ptr_write and (q.reg_ptr == SFR_REG_WRPOS && op_mode != SFR_MODE_OFF)
        |=> q.wr_pos == $past(ev.data[3:0]))
        else $error("write position ignored a write in an active mode");

    AST_RDPOS_TAKE: assert property (
        s_ptr_write and (q.reg_ptr == SFR_REG_RDPOS)
        |=> q.rd_pos == $past(ev.data[3:0]) && q.byte_idx == 2'h0)
        else $error("read position write not taken");

    AST_PTR_HOLD: assert property (
        q.sup_s && !smp_valid && !ev.wr && !ev.rd
        |=> q.wr_pos == $past(q.wr_pos) && q.rd_pos == $past(q.rd_pos))
        else $error("pointers moved without a sample or host access");

    AST_FULL_DROP: assert property (
        q.sup_s && q.full && smp_valid && !ev.wr && !ev.rd
        |=> q.wr_pos == $past(q.wr_pos))
        else $error("full fifo stored a sample");

    AST_HR_RED_ZERO: assert property (
        push_ok && op_mode == SFR_MODE_HR
        |=> fifo_mem[$past(push_addr)][15:0] == 16'h0000)
        else $error("pulse-only sample kept a red word");

endmodule

// file: design/sfr_i2c_target.sv
// serial target engine: pin sampling, framing, byte events
module sfr_i2c_target import sfr_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [7:0] rd_byte,
    output logic            sda_o,
    output logic            sda_oe,
    output sfr_ev_s         ev
);

    typedef struct packed {
        logic       scl_m, scl_s, scl_d;
        logic       sda_m, sda_s, sda_d;
        sfr_i2c_e   st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic       rw;
        logic       first;
        logic       oe;
        logic       lvl;
        sfr_ev_s    ev;
    } sfr_i2c_s;

    localparam sfr_i2c_s SFR_I2C_RST = '{st: SFR_IDLE, default: '0};

    sfr_i2c_s q, n;
    logic     scl_rise, scl_fall, start_c, stop_c;

    // edges come only from the second and third stages
    assign scl_rise = q.scl_s & ~q.scl_d;
    assign scl_fall = ~q.scl_s & q.scl_d;
    assign start_c  = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
    assign stop_c   = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;

    // framing; read bytes are taken at the falling edge that starts them
    always_comb begin
        n = q;
        n.scl_m = scl_i;
        n.scl_s = q.scl_m;
        n.scl_d = q.scl_s;
        n.sda_m = sda_i;
        n.sda_s = q.sda_m;
        n.sda_d = q.sda_s;
        n.ev = '0;
        n.lvl = 1'b0;
        if (start_c) begin
            n.st = SFR_ADDR;
            n.bitcnt = '0;
            n.oe = 1'b0;
        end else if (stop_c) begin
            n.st = SFR_IDLE;
            n.oe = 1'b0;
        end else if (scl_rise) begin
            if (q.st == SFR_ADDR || q.st == SFR_WRB) begin
                n.sh = {q.sh[6:0], q.sda_s};
                n.bitcnt = q.bitcnt + 4'h1;
            end else if (q.st == SFR_MACK && q.sda_s) begin
                n.st = SFR_IDLE; // controller nack ends the read
            end
        end else if (scl_fall) begin
            case (q.st)
                SFR_ADDR: begin
                    if (q.bitcnt == SFR_BITS) begin
                        n.st = (q.sh[7:1] == SFR_DEV_ADDR) ? SFR_AACK : SFR_IDLE;
                        n.oe = (q.sh[7:1] == SFR_DEV_ADDR);
                        n.rw = q.sh[0];
                    end
                end
                SFR_WRB: begin
                    if (q.bitcnt == SFR_BITS) begin
                        n.st = SFR_WACK;
                        n.oe = 1'b1;
                        n.ev.wr = 1'b1;
                        n.ev.ptr = q.first;
                        n.ev.data = q.sh;
                        n.first = 1'b0;
                    end
                end
                SFR_WACK: begin
                    n.st = SFR_WRB;
                    n.oe = 1'b0;
                    n.bitcnt = '0;
                end
                SFR_AACK, SFR_MACK: begin
                    if (q.st == SFR_AACK && !q.rw) begin
                        n.st = SFR_WRB;
                        n.oe = 1'b0;
                        n.bitcnt = '0;
                        n.first = 1'b1;
                    end else begin
                        n.st = SFR_RDB;
                        n.sh = rd_byte;
                        n.oe = ~rd_byte[7];
                        n.bitcnt = 4'h1;
                        n.ev.rd = 1'b1;
                    end
                end
                SFR_RDB: begin
                    if (q.bitcnt == SFR_BITS) begin
                        n.st = SFR_MACK;
                        n.oe = 1'b0;
                    end else begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.oe = ~q.sh[6];
                        n.bitcnt = q.bitcnt + 4'h1;
                    end
                end
                default: n.oe = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= SFR_I2C_RST;
        end else begin
            q <= n;
        end
    end

    assign sda_o  = q.lvl;
    assign sda_oe = q.oe;
    assign ev     = q.ev;

endmodule

// file: inc/sfr_pkg.sv
// shared constants and types for the sample fifo register block
package sfr_pkg;

    // register offsets
    localparam logic [7:0] SFR_REG_STATUS = 8'h00;
    localparam logic [7:0] SFR_REG_MASK   = 8'h01;
    localparam logic [7:0] SFR_REG_WRPOS  = 8'h02;
    localparam logic [7:0] SFR_REG_LOST   = 8'h03;
    localparam logic [7:0] SFR_REG_RDPOS  = 8'h04;
    localparam logic [7:0] SFR_REG_DATA   = 8'h05;
    localparam logic [7:0] SFR_REG_LAST   = 8'hFF;

    // field positions: event flags and masks sit in bits 7:4, supply flag in bit 0
    localparam int SFR_EVT_LSB  = 4;
    localparam int SFR_PWR_BIT  = 0;
    localparam int SFR_F_AFULL  = 3;
    localparam int SFR_F_TEMP   = 2;
    localparam int SFR_F_PULSE  = 1;
    localparam int SFR_F_OXI    = 0;

    // reset values
    localparam logic [3:0] SFR_MASK_RST  = 4'h0;
    localparam logic [3:0] SFR_PTR_RST   = 4'h0;
    localparam logic [3:0] SFR_LOST_RST  = 4'h0;
    localparam logic [3:0] SFR_LOST_MAX  = 4'hF;
    localparam logic [7:0] SFR_RDATA_RST = 8'h00;

    // operating modes as seen on the mode input
    localparam logic [2:0] SFR_MODE_OFF  = 3'h0;
    localparam logic [2:0] SFR_MODE_HR   = 3'h2;
    localparam logic [2:0] SFR_MODE_OXI  = 3'h3;

    // fifo geometry
    localparam int SFR_DEPTH = 16;
    localparam logic [1:0] SFR_LAST_BYTE = 2'h3;

    // serial target address; value is arbitrary
    localparam logic [6:0] SFR_DEV_ADDR = 7'h2A;
    localparam logic [3:0] SFR_BITS     = 4'h8;

    // serial engine states
    typedef enum logic [2:0] {
        SFR_IDLE, SFR_ADDR, SFR_AACK, SFR_WRB, SFR_WACK, SFR_RDB, SFR_MACK
    } sfr_i2c_e;

    // byte events from the serial engine to the register core
    typedef struct packed {
        logic       wr;     // one received data byte
        logic       ptr;    // the byte is the register address
        logic       rd;     // one byte taken for transmit
        logic [7:0] data;
    } sfr_ev_s;

endpackage

// file: tb/sfr_host.sv
// serial controller model of the host processor on the open-drain bus
module sfr_host import sfr_pkg::*; (
    output logic      scl,
    output logic      pull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rb [0:15];
    int         nacks = 0;
    // bus released: the host drives the clock high and the pull-up holds data high between frames
    initial scl = 1'b1;
    initial pull = 1'b0;
    // clock low 100 ns, high 60 ns; data moves mid low phase
    task automatic bit_out(input logic b);
        #50 pull = ~b;
        #50 scl = 1'b1;
        #60 scl = 1'b0;
    endtask
    // late release keeps data still across the clock fall
    task automatic bit_in(output logic b);
        #20 pull = 1'b0;
        #80 scl = 1'b1;
        #30 b = sda;
        #30 scl = 1'b0;
    endtask
    // lv high: start or repeated start, clock left low; lv low: stop, clock idles high after
    task automatic frame(input logic lv);
        #20 pull = ~lv;
        #80 scl = 1'b1;
        #60 pull = lv;
        #60 scl = ~lv;
    endtask
    task automatic wbyte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_in(a);
        if (a) nacks++;
    endtask
    // one register write; callers keep reserved bits zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        frame(1'b1);
        wbyte({SFR_DEV_ADDR, 1'b0});
        wbyte(a);
        wbyte(d);
        frame(1'b0);
    endtask
    // burst read after repeated start; the last byte is not acknowledged
    task automatic rd(input logic [7:0] a, input int n);
        frame(1'b1);
        wbyte({SFR_DEV_ADDR, 1'b0});
        wbyte(a);
        frame(1'b1);
        wbyte({SFR_DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++) begin
            for (int j = 7; j >= 0; j--) bit_in(rb[i][j]);
            bit_out(i == n - 1);
        end
        frame(1'b0);
    endtask
endmodule

// file: tb/test_sample_fifo_interrupt_regs.sv
// self-checking bench for the sample fifo register block
module test_sample_fifo_interrupt_regs import sfr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, srst, supply_ok, smp_valid, temp_done;
    logic        scl, pull, sda, sda_o, sda_oe, irq_n;
    logic [2:0]  op_mode;
    logic [1:0]  smp_res;
    logic [15:0] smp_ir, smp_red;
    int          n_fail = 0, checked = 0, cyc = 0;
    // open-drain data line with pull-up: low while either side pulls
    assign sda = ~((sda_oe & ~sda_o) | pull);
    sfr_core i_sfr_core (
        .mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq_n(irq_n), .supply_ok(supply_ok), .op_mode(op_mode),
        .smp_valid(smp_valid), .smp_ir(smp_ir), .smp_red(smp_red), .smp_res(smp_res),
        .temp_done(temp_done)
    );
    sfr_host i_sfr_host (.scl(scl), .pull(pull), .sda(sda));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // hang guard, about three times the expected run
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic [7:0] rb(input int i);
        return i_sfr_host.rb[i];
    endfunction
    task automatic rd1(input logic [7:0] a, input logic [7:0] e);
        i_sfr_host.rd(a, 1);
        chk(rb(0), e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // one-cycle pulse, then room for flag and interrupt to settle
    task automatic temp_pulse();
        tick(1);
        temp_done = 1'b1;
        tick(1);
        temp_done = 1'b0;
        tick(3);
    endtask
    task automatic push(input logic [15:0] ir, red, input logic [1:0] res);
        tick(1);
        {smp_valid, smp_ir, smp_red, smp_res} = {1'b1, ir, red, res};
        tick(1);
        smp_valid = 1'b0;
    endtask
    // empty fifo before an acquisition
    task automatic clear_fifo(input logic [2:0] m);
        tick(1);
        op_mode = m;
        i_sfr_host.wr(SFR_REG_WRPOS, 8'h00);
        i_sfr_host.wr(SFR_REG_LOST, 8'h00);
        i_sfr_host.wr(SFR_REG_RDPOS, 8'h00);
    endtask
    // supply flag, masking, and flag clearing by status reads
    task automatic t_irq();
        chk({7'h00, irq_n}, 8'h00);
        i_sfr_host.rd(SFR_REG_STATUS, 2);
        chk(rb(0), 8'h01);
        chk(rb(1), 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        i_sfr_host.wr(SFR_REG_MASK, 8'hF0);
        rd1(SFR_REG_MASK, 8'hF0);
        i_sfr_host.wr(SFR_REG_MASK, 8'h00);
        temp_pulse();
        chk({7'h00, irq_n}, 8'h01);
        rd1(SFR_REG_STATUS, 8'h40);
        i_sfr_host.wr(SFR_REG_MASK, 8'h40);
        temp_pulse();
        chk({7'h00, irq_n}, 8'h00);
        rd1(SFR_REG_STATUS, 8'h40);
        chk({7'h00, irq_n}, 8'h01);
        $display("test interrupts done");
    endtask
    // sample layout, justification, partial reads, data port address hold
    task automatic t_fifo();
        logic [7:0] e [0:9] = '{8'hAB, 8'hCD, 8'h55, 8'hE0, 8'hFF,
                                8'hF8, 8'hFF, 8'hFE, 8'h00, 8'h00};
        clear_fifo(SFR_MODE_OXI);
        push(16'h1234, 16'hABCD, 2'h3);
        push(16'h0ABC, 16'h1FFF, 2'h0);
        tick(1);
        op_mode = SFR_MODE_HR;
        push(16'h7FFF, 16'h0123, 2'h2);
        i_sfr_host.rd(SFR_REG_DATA, 2);
        chk(rb(0), 8'h12);
        chk(rb(1), 8'h34);
        rd1(SFR_REG_RDPOS, 8'h00);
        i_sfr_host.rd(SFR_REG_DATA, 10);
        for (int i = 0; i < 10; i++) chk(rb(i), e[i]);
        i_sfr_host.rd(SFR_REG_WRPOS, 3);
        chk(rb(0), 8'h03);
        chk(rb(2), 8'h03);
        $display("test fifo done");
    endtask
    // overflow saturation, almost-full, re-fetch, write position guard
    task automatic t_ovf();
        clear_fifo(SFR_MODE_OXI);
        rd1(SFR_REG_STATUS, 8'h00);
        for (int k = 0; k < 33; k++) begin
            push({12'hC00, k[3:0]}, {12'h0F0, k[3:0]}, 2'h3);
            if (k == 14) rd1(SFR_REG_STATUS, 8'hB0);
        end
        i_sfr_host.rd(SFR_REG_WRPOS, 3);
        chk(rb(0), 8'h00);
        chk(rb(1), 8'h0F);
        i_sfr_host.rd(SFR_REG_DATA, 4);
        chk(rb(1), 8'h00);
        chk(rb(2), 8'h0F);
        i_sfr_host.rd(SFR_REG_LOST, 2);
        chk(rb(0), 8'h00);
        chk(rb(1), 8'h01);
        i_sfr_host.wr(SFR_REG_RDPOS, 8'h00);
        i_sfr_host.rd(SFR_REG_DATA, 4);
        chk(rb(0), 8'hC0);
        chk(rb(2), 8'h0F);
        tick(1);
        op_mode = SFR_MODE_OFF;
        i_sfr_host.wr(SFR_REG_WRPOS, 8'h05);
        rd1(SFR_REG_WRPOS, 8'h00);
        rd1(SFR_REG_RDPOS, 8'h01);
        tick(1);
        op_mode = SFR_MODE_HR;
        i_sfr_host.wr(SFR_REG_WRPOS, 8'h05);
        rd1(SFR_REG_WRPOS, 8'h05);
        $display("test overflow done");
    endtask
    // a burst past the top address must not wrap onto the status register
    task automatic t_top();
        temp_pulse();
        i_sfr_host.rd(8'hFE, 3);
        for (int i = 0; i < 3; i++) chk(rb(i), 8'h00);
        rd1(SFR_REG_STATUS, 8'h40);
        $display("test top address done");
    endtask
    // brownout returns flags, mask and pointers to reset values
    task automatic t_brown();
        tick(1);
        supply_ok = 1'b0;
        tick(6);
        supply_ok = 1'b1;
        tick(6);
        chk({7'h00, irq_n}, 8'h00);
        i_sfr_host.rd(SFR_REG_STATUS, 5);
        chk(rb(0), 8'h01);
        chk(rb(1), 8'h00);
        chk(rb(2), 8'h00);
        chk(rb(4), 8'h00);
        chk(i_sfr_host.nacks[7:0], 8'h00);
        $display("test brownout done");
    endtask
    // main sequence: reset for eight cycles, then each test in turn
    initial begin
        {srst, supply_ok, op_mode} = {1'b1, 1'b1, SFR_MODE_OFF};
        {smp_valid, temp_done, smp_ir, smp_red, smp_res} = '0;
        tick(8);
        srst = 1'b0;
        tick(6);
        t_irq();
        t_fifo();
        t_ovf();
        t_top();
        t_brown();
        conclude();
    end
endmodule
